//--- verilog/tbc_time_base.sv
// Two 16-bit time-base counters of a counter array behind an AHB-Lite
// slave. Assumes the module capture/compare datapaths sit outside and
// report their events and interrupt enables on plain ports.
//
// What this block does
// - Each counter is 16 bits, split into low and high byte registers.
// - Prescaler divides by 1, 2, 4, 8, 12, 16, 32, 64, 128 or 256.
// - With prescaled source, low byte advances at each prescaler overflow.
// - With timer source, low byte advances on each timer 0 overflow.
// - With external source, low byte advances on each pin falling edge.
// - High byte increments in the same step the low byte overflows.
// - Idle-stop set halts counting while the processor idles.
// - Auto-reset clear: free 16-bit count, overflow flag on wrap.
// - Free mode with wide PWM lets modules 0, 2, 4 make 16-bit PWM.
// - 8-bit auto-reset: low reaching high sets flag, clears low, updates.
// - 16-bit auto-reset: match with module 0 pair sets flag, clears.
// - At 16-bit auto-reset, module 0 pair loads from module 1 pair.
// - Setup register fields: idle stop, auto reset, wide PWM, source, enable.
// - Overflow flag requests the interrupt only while its enable is set.
// - Overflow flag set by hardware or software, cleared only by software.
// - Counter advances only while the run bit is set.
// - Module event flags set by hardware, cleared only by software.
// - Run-and-flags register: overflow bit 7, run bit 6, events 5 to 0.
// - Six module events and overflow share one interrupt line.
// - Two identical counter instances, each with its own registers.
`timescale 1ns/1ps
`include "tbc_map.svh"

module tbc_time_base
  import tbc_pkg::*;
#(
  parameter int ADDR_W     = 12,
  parameter int NUM_ARRAYS = 2
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  input  wire logic              hsel_i,
  input  wire logic [ADDR_W-1:0] haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic      [31:0]       hrdata_o,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  input  wire logic              cpu_idle_i,
  input  wire logic              timer0_ovf_i,
  input  wire logic [1:0]        external_count_pin_i,
  input  wire logic [5:0]        module_event_a0_i,
  input  wire logic [5:0]        module_event_a1_i,
  input  wire logic [5:0]        module_irq_en_a0_i,
  input  wire logic [5:0]        module_irq_en_a1_i,
  output logic      [1:0]        irq_o,
  output logic      [1:0]        pwm_update_o,
  output logic      [31:0]       count_o
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // Decode uses address bits 11 to 2.
  // The map holds exactly two counters.
  if (ADDR_W < 12) begin : g_bad_addr
    $error("ADDR_W must be at least 12 to reach every register.");
  end
  if (NUM_ARRAYS != 2) begin : g_bad_arrays
    $error("The register map serves exactly two counters.");
  end

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Terminal value of the prescaler for a select code.
  // The prescaler runs 0 to this end,
  // so divide N ends at N-1.
  function automatic logic [7:0] presc_last(input logic [3:0] src);
    logic [7:0] v;
    v = 8'h00;
    unique case (src)
      `TBC_SRC_DIV1:   v = 8'h00;
      `TBC_SRC_DIV2:   v = 8'h01;
      `TBC_SRC_DIV4:   v = 8'h03;
      `TBC_SRC_DIV8:   v = 8'h07;
      `TBC_SRC_DIV12:  v = 8'h0B;
      `TBC_SRC_DIV16:  v = 8'h0F;
      `TBC_SRC_DIV32:  v = 8'h1F;
      `TBC_SRC_DIV64:  v = 8'h3F;
      `TBC_SRC_DIV128: v = 8'h7F;
      `TBC_SRC_DIV256: v = 8'hFF;
      default:         v = 8'h00;
    endcase
    return v;
  endfunction

  // Maps a word index to a counter and one of its registers.
  // Unmapped: writes drop, reads give 0.
  // Counter 0 leaves two unmapped words after its setup register; counter 1 leaves none.
  function automatic tbc_dec_s decode(input logic [9:0] idx);
    tbc_dec_s r;
    r.arr = 1'b0;
    r.sel = TBC_REG_NONE;
    unique case (idx)
      `TBC_IDX_A0_RUN_FLAGS: r.sel = TBC_REG_RUN_FLAGS;
      `TBC_IDX_A0_SETUP:     r.sel = TBC_REG_SETUP;
      `TBC_IDX_A0_CNT_LOW:   r.sel = TBC_REG_CNT_LOW;
      `TBC_IDX_A0_CNT_HIGH:  r.sel = TBC_REG_CNT_HIGH;
      `TBC_IDX_A0_CAP0_LOW:  r.sel = TBC_REG_CAP0_LOW;
      `TBC_IDX_A0_CAP0_HIGH: r.sel = TBC_REG_CAP0_HIGH;
      `TBC_IDX_A0_CAP1_LOW:  r.sel = TBC_REG_CAP1_LOW;
      `TBC_IDX_A0_CAP1_HIGH: r.sel = TBC_REG_CAP1_HIGH;
      `TBC_IDX_A1_RUN_FLAGS: r = '{1'b1, TBC_REG_RUN_FLAGS};
      `TBC_IDX_A1_SETUP:     r = '{1'b1, TBC_REG_SETUP};
      `TBC_IDX_A1_CNT_LOW:   r = '{1'b1, TBC_REG_CNT_LOW};
      `TBC_IDX_A1_CNT_HIGH:  r = '{1'b1, TBC_REG_CNT_HIGH};
      `TBC_IDX_A1_CAP0_LOW:  r = '{1'b1, TBC_REG_CAP0_LOW};
      `TBC_IDX_A1_CAP0_HIGH: r = '{1'b1, TBC_REG_CAP0_HIGH};
      `TBC_IDX_A1_CAP1_LOW:  r = '{1'b1, TBC_REG_CAP1_LOW};
      `TBC_IDX_A1_CAP1_HIGH: r = '{1'b1, TBC_REG_CAP1_HIGH};
      default:               r.sel = TBC_REG_NONE;
    endcase
    return r;
  endfunction

  // Read value of one register of one counter.
  function automatic logic [7:0] read_reg(input tbc_arr_s a,
                                          input tbc_reg_e sel);
    logic [7:0] v;
    v = 8'h00;
    unique case (sel)
      TBC_REG_NONE:      v = 8'h00;
      TBC_REG_RUN_FLAGS: v = a.run_flags;
      TBC_REG_SETUP:     v = a.setup;
      TBC_REG_CNT_LOW:   v = a.cnt_low;
      TBC_REG_CNT_HIGH:  v = a.cnt_high;
      TBC_REG_CAP0_LOW:  v = a.cap0_low;
      TBC_REG_CAP0_HIGH: v = a.cap0_high;
      TBC_REG_CAP1_LOW:  v = a.cap1_low;
      TBC_REG_CAP1_HIGH: v = a.cap1_high;
    endcase
    return v;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  tbc_state_s state_q;
  tbc_state_s state_d;

  // One comb process builds the next
  // state of both counters and the bus
  // slave; one flop stage holds it.

  always_comb begin
    logic [5:0]  evt;
    logic [5:0]  evt_en;
    logic [3:0]  src;
    logic        fall;
    logic        tick;
    logic        step;
    logic        ovf_set;
    logic        upd;
    logic [15:0] cnt;
    logic [15:0] nxt;
    logic        take;
    tbc_dec_s    wdec;
    tbc_dec_s    rdec;
    logic [7:0]  wb;
    evt     = 6'h00;
    evt_en  = 6'h00;
    src     = 4'h0;
    fall    = 1'b0;
    tick    = 1'b0;
    step    = 1'b0;
    ovf_set = 1'b0;
    upd     = 1'b0;
    cnt     = 16'h0000;
    nxt     = 16'h0000;
    wdec    = decode(state_q.ap_idx);
    rdec    = wdec;
    wb      = hwdata_i[7:0];
    state_d = state_q;

    for (int n = 0; n < 2; n++) begin
      evt    = (n == 0) ? module_event_a0_i : module_event_a1_i;
      evt_en = (n == 0) ? module_irq_en_a0_i : module_irq_en_a1_i;
      src    = state_q.arr[n].setup[`TBC_SU_SRC_MSB:`TBC_SU_SRC_LSB];

      // -------------------------------------------------------------
      // Count pin: three stages, a level is taken when two agree
      // -------------------------------------------------------------
      // An async pin: stage one may go
      // metastable; only stage two reads it.
      // A fall counts three to four clocks
      // late. The level resets low, so the
      // idle-high pin gives no false fall.
      state_d.arr[n].pin_sync = {state_q.arr[n].pin_sync[1:0],
                                 external_count_pin_i[n]};
      fall = 1'b0;
      if (state_q.arr[n].pin_sync[1] == state_q.arr[n].pin_sync[2]) begin
        state_d.arr[n].pin_level = state_q.arr[n].pin_sync[2];
        fall = state_q.arr[n].pin_level &
               ~state_q.arr[n].pin_sync[2];
      end

      // -------------------------------------------------------------
      // Count source and gating
      // -------------------------------------------------------------
      // The prescaler holds while gated,
      // so a pause keeps the divide phase.
      // A prescaler past a new, smaller end
      // wraps at the next step.
      step = state_q.arr[n].run_flags[`TBC_RF_RUN_BIT] &
             ~(cpu_idle_i &
               state_q.arr[n].setup[`TBC_SU_IDLE_STOP_BIT]);
      tick = 1'b0;
      if (src <= `TBC_SRC_DIV256) begin
        if (step) begin
          if (state_q.arr[n].presc >= presc_last(src)) begin
            state_d.arr[n].presc = `TBC_RST_PRESC;
            tick = 1'b1;
          end else begin
            state_d.arr[n].presc = state_q.arr[n].presc + 8'h01;
          end
        end
      end else if (src == `TBC_SRC_TIMER0) begin
        tick = timer0_ovf_i;
      end else if (src == `TBC_SRC_EXT_PIN) begin
        tick = fall;
      end
      step = step & tick;

      // -------------------------------------------------------------
      // Counter modes
      // -------------------------------------------------------------
      // Matches test the value before the
      // step: the 8-bit period is the high
      // byte plus one ticks, the 16-bit one
      // the module 0 pair plus one. The high
      // byte stays put in 8-bit mode.
      cnt     = {state_q.arr[n].cnt_high, state_q.arr[n].cnt_low};
      nxt     = cnt;
      ovf_set = 1'b0;
      upd     = 1'b0;
      if (step) begin
        if (!state_q.arr[n].setup[`TBC_SU_AUTO_RESET_BIT]) begin
          // Free running; the wide PWM bit only changes module use.
          nxt     = cnt + 16'h0001;
          ovf_set = (cnt == 16'hFFFF);
        end else if (!state_q.arr[n].setup[`TBC_SU_WIDE_PWM_BIT]) begin
          if (state_q.arr[n].cnt_low == state_q.arr[n].cnt_high) begin
            nxt[7:0] = 8'h00;
            ovf_set  = 1'b1;
            upd      = 1'b1;
          end else begin
            nxt[7:0] = state_q.arr[n].cnt_low + 8'h01;
          end
        end else begin
          if (cnt == {state_q.arr[n].cap0_high,
                      state_q.arr[n].cap0_low}) begin
            nxt     = 16'h0000;
            ovf_set = 1'b1;
            upd     = 1'b1;
            state_d.arr[n].cap0_high = state_q.arr[n].cap1_high;
            state_d.arr[n].cap0_low  = state_q.arr[n].cap1_low;
          end else begin
            nxt = cnt + 16'h0001;
          end
        end
      end
      state_d.arr[n].cnt_high   = nxt[15:8];
      state_d.arr[n].cnt_low    = nxt[7:0];
      state_d.arr[n].pwm_update = upd;

      // -------------------------------------------------------------
      // Flags; a hardware set wins over a software clear
      // -------------------------------------------------------------
      // A write stores its bits ORed with
      // same-cycle hardware sets, so no
      // event is lost; writing 1 sets a flag.
      take = state_q.wr_pend && (wdec.arr == n[0]);
      if (take && wdec.sel == TBC_REG_RUN_FLAGS) begin
        state_d.arr[n].run_flags = wb | {ovf_set, 1'b0, evt};
      end else begin
        state_d.arr[n].run_flags = state_q.arr[n].run_flags |
                                   {ovf_set, 1'b0, evt};
      end

      // -------------------------------------------------------------
      // Software writes; count bytes override a same-cycle step
      // -------------------------------------------------------------
      // Count bytes move one at a time; a
      // running counter may carry between
      // two reads. Stop it for a clean pair.
      if (take) begin
        unique case (wdec.sel)
          TBC_REG_NONE:      ;
          TBC_REG_RUN_FLAGS: ;
          TBC_REG_SETUP:     state_d.arr[n].setup = wb;
          TBC_REG_CNT_LOW:   state_d.arr[n].cnt_low = wb;
          TBC_REG_CNT_HIGH:  state_d.arr[n].cnt_high = wb;
          TBC_REG_CAP0_LOW:  state_d.arr[n].cap0_low = wb;
          TBC_REG_CAP0_HIGH: state_d.arr[n].cap0_high = wb;
          TBC_REG_CAP1_LOW:  state_d.arr[n].cap1_low = wb;
          TBC_REG_CAP1_HIGH: state_d.arr[n].cap1_high = wb;
        endcase
      end

      // -------------------------------------------------------------
      // Shared interrupt request
      // -------------------------------------------------------------
      // Registered: the request follows
      // its flag a clock later, glitch-free.
      state_d.arr[n].irq =
        (state_q.arr[n].run_flags[`TBC_RF_OVF_BIT] &
         state_q.arr[n].setup[`TBC_SU_OVF_IRQ_EN_BIT]) |
        (|(state_q.arr[n].run_flags[5:0] & evt_en));
    end

    // ---------------------------------------------------------------
    // AHB-Lite slave: writes take no wait, reads take one
    // ---------------------------------------------------------------
    // Only byte lane 0 carries data and
    // hsize is not checked. Read data
    // comes from a flop, at the cost of
    // one wait state. An address phase
    // offered in that wait is not taken.
    state_d.wr_pend = 1'b0;
    state_d.hready  = 1'b1;
    if (state_q.rd_pend) begin
      state_d.rd_pend = 1'b0;
      state_d.hrdata  = {24'h000000,
                         read_reg(state_q.arr[rdec.arr], rdec.sel)};
    end else if (hsel_i && htrans_i[1] && hready_i) begin
      state_d.ap_idx = haddr_i[11:2];
      if (hwrite_i) begin
        state_d.wr_pend = 1'b1;
      end else begin
        state_d.rd_pend = 1'b1;
        state_d.hready  = 1'b0;
      end
    end
  end

  // Reset clears all but hreadyout, which
  // idles high. A low clock enable
  // freezes everything, bus side too.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= '0;
      state_q.hready <= 1'b1;
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all but hresp straight from the state register
  // ---------------------------------------------------------------
  assign hrdata_o     = state_q.hrdata;
  assign hreadyout_o  = state_q.hready;
  // Every transfer is answered OKAY.
  assign hresp_o      = 1'b0;
  assign irq_o        = {state_q.arr[1].irq, state_q.arr[0].irq};
  assign pwm_update_o = {state_q.arr[1].pwm_update,
                         state_q.arr[0].pwm_update};
  assign count_o      = {state_q.arr[1].cnt_high, state_q.arr[1].cnt_low,
                         state_q.arr[0].cnt_high, state_q.arr[0].cnt_low};

endmodule

//--- verilog/tbc_map.svh
// Register indices, field positions, select codes and reset values
// of the counter-array time base.
// Assumes inclusion by its bare name from the module and the testbench.
`ifndef TBC_MAP_SVH
`define TBC_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define TBC_IDX_A0_RUN_FLAGS   10'h0AC
`define TBC_IDX_A0_SETUP       10'h0AD
`define TBC_IDX_A0_CNT_LOW     10'h0B0
`define TBC_IDX_A0_CNT_HIGH    10'h0B1
`define TBC_IDX_A0_CAP0_LOW    10'h0B2
`define TBC_IDX_A0_CAP0_HIGH   10'h0B3
`define TBC_IDX_A0_CAP1_LOW    10'h0B4
`define TBC_IDX_A0_CAP1_HIGH   10'h0B5
`define TBC_IDX_A1_RUN_FLAGS   10'h0CE
`define TBC_IDX_A1_SETUP       10'h0CF
`define TBC_IDX_A1_CNT_LOW     10'h0D0
`define TBC_IDX_A1_CNT_HIGH    10'h0D1
`define TBC_IDX_A1_CAP0_LOW    10'h0D2
`define TBC_IDX_A1_CAP0_HIGH   10'h0D3
`define TBC_IDX_A1_CAP1_LOW    10'h0D4
`define TBC_IDX_A1_CAP1_HIGH   10'h0D5

// Run-and-flags register fields.
`define TBC_RF_OVF_BIT         7
`define TBC_RF_RUN_BIT         6

// Counter-setup register fields.
`define TBC_SU_IDLE_STOP_BIT   7
`define TBC_SU_AUTO_RESET_BIT  6
`define TBC_SU_WIDE_PWM_BIT    5
`define TBC_SU_SRC_MSB         4
`define TBC_SU_SRC_LSB         1
`define TBC_SU_OVF_IRQ_EN_BIT  0

// Count source select codes; codes above the external pin stop counting.
`define TBC_SRC_DIV1           4'h0
`define TBC_SRC_DIV2           4'h1
`define TBC_SRC_DIV4           4'h2
`define TBC_SRC_DIV8           4'h3
`define TBC_SRC_DIV12          4'h4
`define TBC_SRC_DIV16          4'h5
`define TBC_SRC_DIV32          4'h6
`define TBC_SRC_DIV64          4'h7
`define TBC_SRC_DIV128         4'h8
`define TBC_SRC_DIV256         4'h9
`define TBC_SRC_TIMER0         4'hA
`define TBC_SRC_EXT_PIN        4'hB

// Reset values.
`define TBC_RST_BYTE           8'h00
`define TBC_RST_PRESC          8'h00

`endif

//--- verilog/tbc_pkg.sv
// Types shared by the counter-array time base.
// Assumes the constant header tbc_map.svh is on the include path.
package tbc_pkg;

  typedef enum logic [3:0] {
    TBC_REG_NONE,
    TBC_REG_RUN_FLAGS,
    TBC_REG_SETUP,
    TBC_REG_CNT_LOW,
    TBC_REG_CNT_HIGH,
    TBC_REG_CAP0_LOW,
    TBC_REG_CAP0_HIGH,
    TBC_REG_CAP1_LOW,
    TBC_REG_CAP1_HIGH
  } tbc_reg_e;

  typedef struct packed {
    logic     arr;
    tbc_reg_e sel;
  } tbc_dec_s;

  typedef struct packed {
    logic [7:0] run_flags;
    logic [7:0] setup;
    logic [7:0] cnt_low;
    logic [7:0] cnt_high;
    logic [7:0] cap0_low;
    logic [7:0] cap0_high;
    logic [7:0] cap1_low;
    logic [7:0] cap1_high;
    logic [7:0] presc;
    logic [2:0] pin_sync;
    logic       pin_level;
    logic       irq;
    logic       pwm_update;
  } tbc_arr_s;

  typedef struct packed {
    tbc_arr_s [1:0] arr;
    logic           wr_pend;
    logic           rd_pend;
    logic [9:0]     ap_idx;
    logic           hready;
    logic [31:0]    hrdata;
  } tbc_state_s;

endpackage

//--- test/tbc_far_side.sv
// Far-side model: general timer overflow pulses and external count pins.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
module tbc_far_side (
  input  wire logic       clk_i,
  output logic            timer0_ovf_o,
  output logic [1:0]      pin_o
);
  // Pins idle high, as a pulled-up port line does.
  initial begin
    timer0_ovf_o = 1'b0;
    pin_o        = 2'b11;
  end

  task automatic send_ovf(input int n, input int gap);
    repeat (n) begin
      timer0_ovf_o <= 1'b1;
      @(posedge clk_i);
      timer0_ovf_o <= 1'b0;
      @(posedge clk_i);
      repeat (gap) @(posedge clk_i);
    end
  endtask

  // A gap of two or more cycles keeps the pin within a quarter of the clock rate.
  task automatic send_falls(input int ch, input int n, input int gap);
    repeat (n) begin
      pin_o[ch] <= 1'b0;
      repeat (gap) @(posedge clk_i);
      pin_o[ch] <= 1'b1;
      repeat (gap) @(posedge clk_i);
    end
  endtask
endmodule

//--- test/tbc_time_base_sva.sv
// Checker for the counter-array time base ports.
// Assumes one bus slave whose hreadyout feeds hready.
`timescale 1ns/1ps
module tbc_time_base_sva (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic        ce_i,
  input wire logic        hsel_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic [5:0]  module_event_a0_i,
  input wire logic [5:0]  module_event_a1_i,
  input wire logic [5:0]  module_irq_en_a0_i,
  input wire logic [5:0]  module_irq_en_a1_i,
  input wire logic [1:0]  irq_o,
  input wire logic [31:0] count_o
);
  logic take;
  logic rd_ph_q;
  logic wr_ph_q;

  assign take = hsel_i & htrans_i[1] & hready_i & ce_i;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_ph_q <= 1'b0;
      wr_ph_q <= 1'b0;
    end else begin
      rd_ph_q <= take & ~hwrite_i;
      wr_ph_q <= take & hwrite_i;
    end
  end

  // Without a bus write a counter only holds, steps by one or clears.
  function automatic logic ok_step(input logic [15:0] c, input logic [15:0] q);
    return c == q || c == q + 16'h1 || c == 16'h0 ||
           (c[7:0] == 8'h0 && c[15:8] == q[15:8]);
  endfunction

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  property p_resp;
    hresp_o == 1'b0;
  endproperty
  a_resp: assert property (p_resp) else $error("bad response");
  property p_rd;
    take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o;
  endproperty
  a_rd: assert property (p_rd) else $error("read wait wrong");
  property p_wr;
    take && hwrite_i |=> hreadyout_o;
  endproperty
  a_wr: assert property (p_wr) else $error("write stalled");
  property p_upper;
    hrdata_o[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper data set");
  property p_hold;
    !$past(rd_ph_q) |-> $stable(hrdata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_step0;
    !$past(wr_ph_q) |-> ok_step(count_o[15:0], $past(count_o[15:0]));
  endproperty
  a_step0: assert property (p_step0) else $error("count 0 jump");
  property p_step1;
    !$past(wr_ph_q) |-> ok_step(count_o[31:16], $past(count_o[31:16]));
  endproperty
  a_step1: assert property (p_step1) else $error("count 1 jump");
  property p_evt0;
    (module_event_a0_i & module_irq_en_a0_i) != 6'h0 |-> ##[1:3] irq_o[0];
  endproperty
  a_evt0: assert property (p_evt0) else $error("no irq 0");
  property p_evt1;
    (module_event_a1_i & module_irq_en_a1_i) != 6'h0 |-> ##[1:3] irq_o[1];
  endproperty
  a_evt1: assert property (p_evt1) else $error("no irq 1");
  property p_keep0;
    irq_o[0] && !wr_ph_q && !$past(wr_ph_q) &&
    $stable(module_irq_en_a0_i) |=> irq_o[0];
  endproperty
  a_keep0: assert property (p_keep0) else $error("flag lost");
endmodule

bind tbc_time_base tbc_time_base_sva i_sva (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .hsel_i(hsel_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .module_event_a0_i(module_event_a0_i),
  .module_event_a1_i(module_event_a1_i),
  .module_irq_en_a0_i(module_irq_en_a0_i),
  .module_irq_en_a1_i(module_irq_en_a1_i), .irq_o(irq_o), .count_o(count_o)
);

//--- test/tbc_time_base_tb_top.sv
// Self-checking testbench for the counter-array time base.
// Assumes the package, map header, far-side model and checker compile first.
`timescale 1ns/1ps
`include "tbc_map.svh"
module tbc_time_base_tb_top;
  localparam logic [9:0] RF0 = `TBC_IDX_A0_RUN_FLAGS;
  localparam logic [9:0] SU0 = `TBC_IDX_A0_SETUP;
  localparam logic [9:0] CL0 = `TBC_IDX_A0_CNT_LOW;
  localparam logic [9:0] CH0 = `TBC_IDX_A0_CNT_HIGH;
  localparam logic [9:0] P0L = `TBC_IDX_A0_CAP0_LOW;
  localparam logic [9:0] P1L = `TBC_IDX_A0_CAP1_LOW;
  localparam logic [9:0] RF1 = `TBC_IDX_A1_RUN_FLAGS;
  localparam logic [9:0] SU1 = `TBC_IDX_A1_SETUP;
  logic        clk_sys, rst_n, hsel, hwrite, hready, cpu_idle, t0_ovf;
  logic [11:0] haddr;
  logic [1:0]  htrans, pins, irq, pwm;
  logic [31:0] hwdata, hrdata, count, v;
  logic [5:0]  ev0, ev1, en0, en1;
  int          fails, total_checks, pwm_cnt, k, p;

  tbc_time_base i_dut (
    .clk_sys_i(clk_sys), .rst_n_i(rst_n), .ce_i(1'b1), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
    .cpu_idle_i(cpu_idle), .timer0_ovf_i(t0_ovf),
    .external_count_pin_i(pins), .module_event_a0_i(ev0),
    .module_event_a1_i(ev1), .module_irq_en_a0_i(en0),
    .module_irq_en_a1_i(en1), .irq_o(irq), .pwm_update_o(pwm),
    .count_o(count)
  );
  tbc_far_side i_far (.clk_i(clk_sys), .timer0_ovf_o(t0_ovf), .pin_o(pins));

  always @(posedge clk_sys) if (pwm[0] === 1'b1) pwm_cnt++;

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] i,
                     input logic [7:0] d, output logic [7:0] q);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {i, 2'b00};
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge clk_sys); while (hready !== 1'b1);
    q = hrdata[7:0];
  endtask
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, i, d, q);
  endtask
  task automatic rc(input logic [9:0] i, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, i, 8'h00, q);
    chk({24'h0, q}, {24'h0, e});
  endtask
  task automatic wait_chg(output int n);
    logic [7:0] o;
    o = count[7:0];
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (count[7:0] === o);
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_regs;
    rc(RF0, 8'h00);
    rc(SU0, 8'h00);
    rc(RF1, 8'h00);
    rc(CL0, 8'h00);
    wr(10'h3F0, 8'h5A);
    rc(10'h3F0, 8'h00);
    wr(SU0, 8'hFB);
    wr(SU1, 8'h5A);
    rc(SU0, 8'hFB);
    rc(SU1, 8'h5A);
    wr(SU0, 8'h00);
    wr(SU1, 8'h00);
  endtask
  task automatic t_presc;
    int dv [10] = '{1, 2, 4, 8, 12, 16, 32, 64, 128, 256};
    wr(RF0, 8'h40);
    for (int c = 0; c < 10; c++) begin
      wr(SU0, {3'b000, c[3:0], 1'b0});
      wait_chg(k);
      wait_chg(k);
      wait_chg(k);
      chk(k, dv[c]);
    end
  endtask
  task automatic t_gate;
    wr(SU0, 8'h80);
    cpu_idle <= 1'b1;
    repeat (3) @(posedge clk_sys);
    v = count;
    repeat (20) @(posedge clk_sys);
    chk(count, v);
    wr(SU0, 8'h00);
    wait_chg(k);
    wait_chg(k);
    chk(k, 1);
    cpu_idle <= 1'b0;
    wr(CL0, 8'h80);
    @(posedge clk_sys);
    chk({24'h0, count[7:0]}, 32'h80);
    wr(RF0, 8'h00);
    @(posedge clk_sys);
    v = count;
    repeat (20) @(posedge clk_sys);
    chk(count, v);
  endtask
  task automatic t_src;
    wr(CL0, 8'h00);
    wr(CH0, 8'h00);
    wr(SU0, 8'h14);
    wr(SU1, 8'h16);
    wr(RF0, 8'h40);
    wr(RF1, 8'h40);
    i_far.send_ovf(5, 1);
    i_far.send_falls(1, 7, 2);
    repeat (8) @(posedge clk_sys);
    chk(count, 32'h0007_0005);
  endtask
  task automatic t_wrap;
    wr(CL0, 8'hFD);
    wr(CH0, 8'hFF);
    wr(SU0, 8'h15);
    i_far.send_ovf(3, 0);
    chk({16'h0, count[15:0]}, 32'h0);
    rc(RF0, 8'hC0);
    chk({31'h0, irq[0]}, 32'h1);
    wr(CL0, 8'hFF);
    wr(CH0, 8'h12);
    i_far.send_ovf(1, 0);
    chk({16'h0, count[15:0]}, 32'h1300);
    wr(RF0, 8'h40);
    rc(RF0, 8'h40);
    chk({31'h0, irq[0]}, 32'h0);
    wr(SU0, 8'h14);
    wr(RF0, 8'hC0);
    rc(RF0, 8'hC0);
    chk({31'h0, irq[0]}, 32'h0);
  endtask
  task automatic t_auto;
    wr(CH0, 8'h03);
    wr(CL0, 8'h00);
    wr(SU0, 8'h54);
    wr(RF0, 8'h40);
    p = pwm_cnt;
    i_far.send_ovf(4, 0);
    repeat (2) @(posedge clk_sys);
    chk(pwm_cnt - p, 1);
    chk({24'h0, count[15:8]}, 32'h03);
    rc(RF0, 8'hC0);
    wr(P0L, 8'h05);
    wr(P1L, 8'h09);
    wr(CL0, 8'h00);
    wr(CH0, 8'h00);
    wr(SU0, 8'h74);
    wr(RF0, 8'h40);
    p = pwm_cnt;
    i_far.send_ovf(6, 0);
    repeat (2) @(posedge clk_sys);
    chk(pwm_cnt - p, 1);
    chk({24'h0, count[15:8]}, 32'h0);
    rc(RF0, 8'hC0);
    rc(P0L, 8'h09);
  endtask
  task automatic t_events;
    en0 <= 6'h04;
    ev0 <= 6'h04;
    @(posedge clk_sys);
    ev0 <= 6'h00;
    repeat (12) @(posedge clk_sys);
    chk({31'h0, irq[0]}, 32'h1);
    rc(RF0, 8'hC4);
    wr(RF0, 8'h40);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq[0]}, 32'h0);
    en1 <= 6'h20;
    ev1 <= 6'h21;
    @(posedge clk_sys);
    ev1 <= 6'h00;
    repeat (3) @(posedge clk_sys);
    chk({31'h0, irq[1]}, 32'h1);
    rc(RF1, 8'h61);
    en1 <= 6'h00;
    repeat (3) @(posedge clk_sys);
    chk({31'h0, irq[1]}, 32'h0);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    {rst_n, hsel, hwrite, cpu_idle, htrans, haddr, hwdata} = '0;
    {ev0, ev1, en0, en1} = '0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_regs;
    t_presc;
    t_gate;
    t_src;
    t_wrap;
    t_auto;
    t_events;
    report_and_stop;
  end
  // The run needs about 2000 cycles; the limit leaves ample room.
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    report_and_stop;
  end
endmodule
